// ---- hw/kfp_handler.sv ----
`include "kfp_consts.svh"
`default_nettype none
module kfp_handler
   import kfp_pkg::*;
#(
   parameter int TICK_CYC = `KFP_TICK_CYC,  // 1/32 s
   parameter int STEP_CYC = `KFP_STEP_CYC   // pwm step
)(
   // clock, reset, enable
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // keypad and key events
   input  wire logic [5:0]  keysIn,
   output logic             keyEvtValid,
   output logic      [2:0]  keyEvtKey,
   output logic             keyEvtRelease,
   // fans
   input  wire logic [3:0]  fanTachIn,
   output logic      [3:0]  fanPowerOut,
   output logic      [3:0]  tachEdge,
   // host power and reset
   input  wire logic        hostOnIn,
   output logic             hostResetOut,
   output logic             hostResetOe,
   output logic             hostPowerOut,
   output logic             hostPowerOe,
   // display and restart
   output logic             displayBlank,
   output logic      [1:0]  msgShow,
   output logic             selfRestart
);
   localparam logic [21:0] TICK_LAST = 22'(TICK_CYC - 1);
   localparam logic [15:0] STEP_LAST = 16'(STEP_CYC - 1);
   localparam logic [8:0] HOLD_LONG = 9'(`KFP_MS2TICK(`KFP_HOLD_LONG_MS));
   localparam logic [8:0] HOLD_SHORT = 9'(`KFP_MS2TICK(`KFP_HOLD_SHORT_MS));
   localparam logic [8:0] RST_PULSE = 9'(`KFP_MS2TICK(`KFP_RESET_PULSE_MS));
   localparam logic [8:0] EXTRA = 9'(`KFP_MS2TICK(`KFP_EXTRA_HOLD_MS));

   // reset image: every key reported, glitch delay one count
   localparam kfp_state_t RST_ST = '{
      pressMask: `KFP_MASK_DEFAULT,
      releaseMask: `KFP_MASK_DEFAULT,  // six keys, down included
      glitch: {4{`KFP_GLITCH_DEFAULT}},
      pulseLen: `KFP_PULSE_DEFAULT,
      sw: SwIdle,
      default: '0};

   kfp_state_t st_r;        // registered state
   kfp_state_t st_nxt;      // next state
   kfp_state_t hold;        // copy kept across restart
   logic       req;         // new bus request
   logic       cmdGo;       // command register written
   logic       pollGo;      // accepted poll
   logic       busy;        // commands refused
   logic       found;       // a key changed
   logic [2:0] pick;        // lowest changed key
   logic [5:0] chg;
   logic [5:0] pNew;        // presses this cycle
   logic [5:0] rNew;        // releases this cycle
   logic [5:0] agK;         // key stages agree
   logic [3:0] agT;         // tach stages agree
   logic       tick;
   logic       step;
   logic       doRestart;
   logic [8:0] cntInc;
   logic [7:0] eff [4];     // effective fan power
   logic [7:0] cT;          // command type
   logic [2:0] cL;          // command length
   logic       ok;

   // next-state logic
   always_comb
   begin
      st_nxt = st_r;
      hold = st_r;
      pick = 3'h0;
      found = 1'b0;
      ok = 1'b1;
      doRestart = 1'b0;
      cT = wb_dat_i[7:0];
      cL = wb_dat_i[10:8];
      for (int f = 0; f < 4; f++)
      begin
         eff[f] = st_r.forced[f] ? `KFP_FULL_POWER : st_r.level[f];
      end
      // pins pass three stages; a bit settles when stages 2 and 3 agree
      st_nxt.keySync = {st_r.keySync[1:0], keysIn};
      st_nxt.hostSync = {st_r.hostSync[1:0], hostOnIn};
      st_nxt.tachSync = {st_r.tachSync[1:0], fanTachIn};
      agK = ~(st_r.keySync[1] ^ st_r.keySync[2]);
      agT = ~(st_r.tachSync[1] ^ st_r.tachSync[2]);
      st_nxt.keys = (st_r.keySync[1] & agK) | (st_r.keys & ~agK);
      st_nxt.tach = (st_r.tachSync[1] & agT) | (st_r.tach & ~agT);
      if (st_r.hostSync[1] == st_r.hostSync[2])
      begin
         st_nxt.hostOn = st_r.hostSync[1];
      end

      // time bases: 1/32 s tick and pwm step
      tick = (st_r.tickCnt == TICK_LAST);
      step = (st_r.stepCnt == STEP_LAST);
      st_nxt.tickCnt = tick ? 22'h0 : st_r.tickCnt + 22'h1;
      st_nxt.stepCnt = step ? 16'h0 : st_r.stepCnt + 16'h1;
      if (step)
      begin
         // hundred steps make one ~18 Hz period
         st_nxt.phase = (st_r.phase == `KFP_PWM_STEPS - 7'h1) ? 7'h0 : st_r.phase + 7'h1;
      end

      // unsolicited events: one key per cycle, lowest index first
      chg = st_r.keys ^ st_r.keysRep;
      for (int i = 5; i >= 0; i--)
      begin
         if (chg[i])
         begin
            pick = 3'(i);
            found = 1'b1;
         end
      end
      st_nxt.evtValid = 1'b0;
      if (found)
      begin
         st_nxt.keysRep[pick] = st_r.keys[pick];
         st_nxt.evtKey = pick;
         st_nxt.evtRelease = ~st_r.keys[pick];
         // masked keys are consumed silently
         st_nxt.evtValid = st_r.keys[pick] ? st_r.pressMask[pick] : st_r.releaseMask[pick];
      end

      // poll history sees every key, masks play no part
      pNew = st_r.keys & ~st_r.keysLast;
      rNew = ~st_r.keys & st_r.keysLast;
      st_nxt.keysLast = st_r.keys;
      st_nxt.pressHist = st_r.pressHist | pNew;
      st_nxt.relHist = st_r.relHist | rNew;

      // fail-safe timer in eighth seconds
      if (tick)
      begin
         st_nxt.failSub = st_r.failSub + 2'h1;
      end
      if (tick && st_r.failSub == `KFP_EIGHTH_SUB && st_r.failCnt < st_r.failTicks)
      begin
         st_nxt.failCnt = st_r.failCnt + 8'h1;
      end
      if (st_r.failMask != 4'h0 && st_r.failCnt >= st_r.failTicks)
      begin
         st_nxt.forced = st_r.forced | st_r.failMask;
      end

      // per-fan pwm and tachometer blanking
      for (int f = 0; f < 4; f++)
      begin
         st_nxt.fanOn[f] = ({1'b0, st_r.phase} < eff[f]);
         if (st_nxt.fanOn[f] && !st_r.fanOn[f])
         begin
            st_nxt.tachBlank[f] = st_r.glitch[f];
         end
         else if (step && st_r.tachBlank[f] != 8'h0)
         begin
            st_nxt.tachBlank[f] = st_r.tachBlank[f] - 8'h1;
         end
         // edge counts only with power on and blanking over
         st_nxt.tachEdge[f] = (st_nxt.tach[f] != st_r.tach[f]) && st_r.fanOn[f]
                              && st_r.tachBlank[f] == 8'h0;
      end

      // power and reset switch sequencer, counts in 1/32 s ticks
      cntInc = st_r.swCnt + 9'h1;
      case (st_r.sw)
         SwIdle:
         begin
            st_nxt.swCnt = 9'h0;
            if (st_r.keys[`KFP_KEY_CONFIRM] &&
                ((st_r.funcMask[`KFP_FN_KP_RESET] && st_r.hostOn) ||
                 (st_r.funcMask[`KFP_FN_KP_ON] && !st_r.hostOn)))
            begin
               st_nxt.sw = SwHoldCheck;
            end
            else if (st_r.keys[`KFP_KEY_ABORT] && st_r.funcMask[`KFP_FN_KP_OFF] && st_r.hostOn)
            begin
               st_nxt.sw = SwHoldAbort;
            end
         end
         SwHoldCheck:
         begin
            if (!st_r.keys[`KFP_KEY_CONFIRM])
            begin
               st_nxt.sw = SwIdle;
            end
            else if (tick)
            begin
               st_nxt.swCnt = cntInc;
               if (st_r.hostOn && st_r.funcMask[`KFP_FN_KP_RESET] && cntInc >= HOLD_LONG)
               begin
                  st_nxt.sw = SwPulseReset;
                  st_nxt.swCnt = 9'h0;
               end
               else if (!st_r.hostOn && st_r.funcMask[`KFP_FN_KP_ON] && cntInc >= HOLD_SHORT)
               begin
                  st_nxt.sw = SwPulsePower;
                  st_nxt.swCnt = 9'h0;
               end
            end
         end
         SwHoldAbort:
         begin
            if (!st_r.keys[`KFP_KEY_ABORT])
            begin
               st_nxt.sw = SwIdle;
            end
            else if (tick)
            begin
               st_nxt.swCnt = cntInc;
               if (cntInc >= HOLD_LONG)
               begin
                  st_nxt.sw = SwPulseOff;
                  st_nxt.swCnt = 9'h0;
               end
            end
         end
         SwPulseReset:
         begin
            if (tick)
            begin
               st_nxt.swCnt = cntInc;
               doRestart = (cntInc >= RST_PULSE);
            end
         end
         SwPulsePower:
         begin
            if (tick)
            begin
               st_nxt.swCnt = cntInc;
               doRestart = (cntInc >= {1'b0, st_r.pulseLen});
            end
         end
         SwPulseOff:
         begin
            // pulse length first, then as long as the key stays, capped
            if (tick)
            begin
               st_nxt.swCnt = cntInc;
               if (cntInc >= {1'b0, st_r.pulseLen} && (!st_r.keys[`KFP_KEY_ABORT] ||
                   cntInc >= {1'b0, st_r.pulseLen} + EXTRA))
               begin
                  st_nxt.sw = SwIdle;
               end
            end
         end
         default:
         begin
            st_nxt.sw = SwIdle;
         end
      endcase
      // lines float unless a pulse is running
      st_nxt.rstOe = (st_nxt.sw == SwPulseReset);
      st_nxt.pwrOe = (st_nxt.sw == SwPulsePower) || (st_nxt.sw == SwPulseOff);
      st_nxt.rstOut = st_nxt.rstOe & st_r.funcMask[`KFP_FN_RST_INV];
      st_nxt.pwrOut = st_nxt.pwrOe & st_r.funcMask[`KFP_FN_PWR_INV];
      case (st_nxt.sw)
         SwPulseReset: st_nxt.msg = `KFP_MSG_RESET;
         SwPulsePower: st_nxt.msg = `KFP_MSG_PWRON;
         SwPulseOff: st_nxt.msg = `KFP_MSG_PWROFF;
         default: st_nxt.msg = `KFP_MSG_NONE;
      endcase

      // display blanking follows host sense
      st_nxt.blank = st_r.funcMask[`KFP_FN_BLANK] & ~st_r.hostOn;
      if (st_r.funcMask[`KFP_FN_BLANK] && !st_r.hostOn && st_nxt.hostOn)
      begin
         doRestart = 1'b1;
      end

      // wishbone: every request acked one cycle later
      req = wb_cyc_i & wb_stb_i & ~st_r.ack;
      st_nxt.ack = req;
      busy = (st_r.sw == SwPulseReset) | st_r.restart;
      cmdGo = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `KFP_ADDR_CMD);
      pollGo = cmdGo & ~busy & (cT == `KFP_CMD_POLL) & (cL == 3'h0);
      if (req && !wb_we_i)
      begin
         case (wb_adr_i)
            `KFP_ADDR_CMD: st_nxt.rdData = {21'h0, st_r.respLen, st_r.respType};
            `KFP_ADDR_DATA: st_nxt.rdData = st_r.cmdData;
            `KFP_ADDR_RESP0: st_nxt.rdData = st_r.resp[3:0];
            `KFP_ADDR_RESP1: st_nxt.rdData = {24'h0, st_r.resp[4]};
            `KFP_ADDR_STATUS: st_nxt.rdData = {20'h0, st_r.blank, st_r.ignored,
                                               busy, st_r.hostOn, 2'h0, st_r.keys};
            default: st_nxt.rdData = 32'h0;
         endcase
      end
      if (req && wb_we_i && wb_adr_i == `KFP_ADDR_DATA)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (wb_sel_i[b])
            begin
               st_nxt.cmdData[8*b +: 8] = wb_dat_i[8*b +: 8];
            end
         end
      end
      // command decode
      if (cmdGo && busy)
      begin
         st_nxt.ignored = 1'b1;
      end
      else if (cmdGo)
      begin
         st_nxt.ignored = 1'b0;
         st_nxt.respLen = 3'h0;
         st_nxt.resp = '0;
         case (cT)
            `KFP_CMD_FANPWR:
            begin
               ok = (cL == 3'h4);
               if (ok)
               begin
                  // fresh power clears the fail-safe
                  st_nxt.level = st_r.cmdData;
                  st_nxt.failCnt = 8'h0;
                  // old forcing cleared; an expiry in this same cycle still wins
                  st_nxt.forced = st_nxt.forced & ~st_r.forced;
               end
            end
            `KFP_CMD_KEYCFG:
            begin
               ok = (cL == 3'h2);
               if (ok)
               begin
                  st_nxt.pressMask = st_r.cmdData[7:0];
                  st_nxt.releaseMask = st_r.cmdData[15:8];
               end
            end
            `KFP_CMD_POLL:
            begin
               ok = (cL == 3'h0);
               if (ok)
               begin
                  // restart history, but a change this cycle survives
                  st_nxt.resp[0] = {2'h0, st_r.keys};
                  st_nxt.resp[1] = {2'h0, st_r.pressHist};
                  st_nxt.resp[2] = {2'h0, st_r.relHist};
                  st_nxt.respLen = 3'h3;
                  st_nxt.pressHist = pNew;
                  st_nxt.relHist = rNew;
               end
            end
            `KFP_CMD_FAILSAFE:
            begin
               ok = (cL == 3'h2);
               if (ok)
               begin
                  st_nxt.failMask = st_r.cmdData[3:0];
                  st_nxt.failTicks = st_r.cmdData[15:8];
                  st_nxt.failCnt = 8'h0;
               end
            end
            `KFP_CMD_GLITCH:
            begin
               ok = (cL == 3'h4);
               if (ok)
               begin
                  st_nxt.glitch = st_r.cmdData;
               end
            end
            `KFP_CMD_QUERY:
            begin
               ok = (cL == 3'h0);
               if (ok)
               begin
                  st_nxt.resp = {{4'h0, st_r.failMask}, eff[3], eff[2], eff[1], eff[0]};
                  st_nxt.respLen = 3'h5;
               end
            end
            `KFP_CMD_ATX:
            begin
               ok = (cL == 3'h1) || (cL == 3'h2);
               if (ok)
               begin
                  st_nxt.funcMask = st_r.cmdData[7:0];
                  st_nxt.pulseLen = (cL == 3'h2) ? st_r.cmdData[15:8] : `KFP_PULSE_DEFAULT;
               end
            end
            default:
            begin
               ok = 1'b0;
            end
         endcase
         st_nxt.respType = cT | (ok ? `KFP_RESP_FLAG : `KFP_ERR_FLAG);
      end

      // restart: runtime cleared, configuration kept as boot state
      st_nxt.restart = doRestart;
      if (doRestart)
      begin
         hold = st_nxt;
         st_nxt = RST_ST;
         st_nxt.restart = 1'b1;
         st_nxt.keySync = hold.keySync;
         st_nxt.hostSync = hold.hostSync;
         st_nxt.tachSync = hold.tachSync;
         st_nxt.keys = hold.keys;
         st_nxt.keysRep = hold.keys;
         st_nxt.keysLast = hold.keys;
         st_nxt.hostOn = hold.hostOn;
         st_nxt.tach = hold.tach;
         st_nxt.pressMask = hold.pressMask;
         st_nxt.releaseMask = hold.releaseMask;
         st_nxt.level = hold.level;
         // fans keep turning and the screen keeps its state through a restart
         st_nxt.fanOn = hold.fanOn;
         st_nxt.blank = hold.blank;
         st_nxt.glitch = hold.glitch;
         st_nxt.funcMask = hold.funcMask;
         st_nxt.pulseLen = hold.pulseLen;
         st_nxt.failMask = hold.failMask;
         st_nxt.failTicks = hold.failTicks;
         st_nxt.ack = hold.ack;
         st_nxt.rdData = hold.rdData;
      end
   end

   // state register, frozen while ce is low
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r <= RST_ST;
      end
      else if (ce)
      begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from state
   assign wb_dat_o = st_r.rdData;
   assign wb_ack_o = st_r.ack;
   assign keyEvtValid = st_r.evtValid;
   assign keyEvtKey = st_r.evtKey;
   assign keyEvtRelease = st_r.evtRelease;
   assign fanPowerOut = st_r.fanOn;
   assign tachEdge = st_r.tachEdge;
   assign hostResetOut = st_r.rstOut;
   assign hostResetOe = st_r.rstOe;
   assign hostPowerOut = st_r.pwrOut;
   assign hostPowerOe = st_r.pwrOe;
   assign displayBlank = st_r.blank;
   assign msgShow = st_r.msg;
   assign selfRestart = st_r.restart;

   // checks
   default clocking cb @(posedge clk iff ce); endclocking
   default disable iff (!rst_b);

   resp_type_a: assert property (cmdGo && !busy && cT == `KFP_CMD_GLITCH && cL == 3'h4
      |=> st_r.respType == 8'h5A && st_r.respLen == 3'h0) else $error("bad answer type");
   press_mask_a: assert property (st_r.evtValid && !st_r.evtRelease
      |-> (($past(st_r.pressMask) >> st_r.evtKey) & 8'h01) != 8'h0) else $error("masked press sent");
   poll_all_a: assert property (pollGo
      |=> st_r.resp[0] == {2'h0, $past(st_r.keys)} && st_r.respLen == 3'h3) else $error("poll lost keys");
   hist_restart_a: assert property (pollGo |=> st_r.pressHist == $past(pNew))
      else $error("history not restarted");
   idle_hiz_a: assert property (st_r.sw == SwIdle |-> !st_r.rstOe && !st_r.pwrOe)
      else $error("line driven while idle");
   rst_pol_a: assert property (st_r.rstOe && $stable(st_r.funcMask)
      |-> st_r.rstOut == st_r.funcMask[`KFP_FN_RST_INV]) else $error("reset polarity");
   rst_pulse_a: assert property ($rose(st_r.rstOe) |-> st_r.rstOe [*8])
      else $error("reset pulse short");
   forced_full_a: assert property (st_r.forced[0] |=> st_r.fanOn[0])
      else $error("forced fan not on");
   pwm_range_a: assert property (st_r.phase < `KFP_PWM_STEPS)
      else $error("pwm phase range");
   tach_blank_a: assert property (st_r.tachEdge[0] |-> $past(st_r.tachBlank[0]) == 8'h0)
      else $error("tach edge in blanking");
   blank_follow_a: assert property (##1 st_r.blank ==
      $past(st_r.funcMask[`KFP_FN_BLANK] & ~st_r.hostOn)) else $error("blank mismatch");

   poll_seen_c: cover property (pollGo);
   reset_pulse_c: cover property ($rose(st_r.rstOe));
   power_pulse_c: cover property ($rose(st_r.pwrOe));
   key_event_c: cover property (st_r.evtValid);
endmodule : kfp_handler
`default_nettype wire

// ---- hw/kfp_consts.svh ----
// What this block does
// - all key events reported after reset
// - key bits up 01 confirm 02 abort 04
// - command 17h loads press/release report masks
// - poll 18h returns held, pressed, released
// - poll ignores report masks
// - fail-safe 19h: fan mask, 1/8s timeout
// - timeout without power update forces full power
// - fan pwm period about 18 Hz
// - ignore tach edges after fan turns on
// - glitch delay defaults to one count
// - command 1Ah loads four glitch counts
// - query 1Bh returns levels and fail-safe mask
// - reset/power lines idle high impedance
// - function bits 02/04 invert pulse polarity
// - function bits 10/20/40/80 enable features
// - confirm 4s pulses reset 1s, restart
// - confirm 0.25s host off pulses power
// - abort 4s pulses power, max 5s more
// - blank while host off, reboot on rise
// - command 1Ch optional 1/32s pulse length
// - answer type is command OR 40h, OR 80h on a bad command or length
`ifndef KFP_CONSTS_SVH
`define KFP_CONSTS_SVH
`define KFP_CLK_NS 10
`define KFP_TICK_US 31250
`define KFP_TICK_CYC ((`KFP_TICK_US * 1000) / `KFP_CLK_NS)
`define KFP_STEP_NS 552500
`define KFP_STEP_CYC (`KFP_STEP_NS / `KFP_CLK_NS)
`define KFP_TICKS_PER_S 32
`define KFP_HOLD_LONG_MS 4000
`define KFP_HOLD_SHORT_MS 250
`define KFP_RESET_PULSE_MS 1000
`define KFP_EXTRA_HOLD_MS 5000
`define KFP_MS2TICK(ms) (((ms) * `KFP_TICKS_PER_S) / 1000)
`define KFP_PWM_STEPS 7'h64
`define KFP_FULL_POWER 8'h64
`define KFP_EIGHTH_SUB 2'h3
`define KFP_PULSE_DEFAULT 8'h20
`define KFP_GLITCH_DEFAULT 8'h01
`define KFP_MASK_DEFAULT 8'h3F
`define KFP_KEY_CONFIRM 1
`define KFP_KEY_ABORT 2
`define KFP_FN_RST_INV 1
`define KFP_FN_PWR_INV 2
`define KFP_FN_BLANK 4
`define KFP_FN_KP_RESET 5
`define KFP_FN_KP_ON 6
`define KFP_FN_KP_OFF 7
`define KFP_CMD_FANPWR 8'h11
`define KFP_CMD_KEYCFG 8'h17
`define KFP_CMD_POLL 8'h18
`define KFP_CMD_FAILSAFE 8'h19
`define KFP_CMD_GLITCH 8'h1A
`define KFP_CMD_QUERY 8'h1B
`define KFP_CMD_ATX 8'h1C
`define KFP_RESP_FLAG 8'h40
`define KFP_ERR_FLAG 8'h80
`define KFP_ADDR_CMD 8'h00
`define KFP_ADDR_DATA 8'h04
`define KFP_ADDR_RESP0 8'h08
`define KFP_ADDR_RESP1 8'h0C
`define KFP_ADDR_STATUS 8'h10
`define KFP_MSG_NONE 2'h0
`define KFP_MSG_RESET 2'h1
`define KFP_MSG_PWRON 2'h2
`define KFP_MSG_PWROFF 2'h3
`endif

// ---- hw/kfp_pkg.sv ----
`default_nettype none
package kfp_pkg;
   // power/reset switch sequencer
   typedef enum logic [2:0] {
      SwIdle, SwHoldCheck, SwHoldAbort, SwPulseReset, SwPulsePower, SwPulseOff
   } kfp_sw_t;
   // whole block state
   typedef struct packed {
      logic [2:0][5:0] keySync;   // [0] first stage
      logic [2:0]      hostSync;
      logic [2:0][3:0] tachSync;
      logic [5:0]      keys;      // settled key levels
      logic            hostOn;
      logic [3:0]      tach;
      logic [5:0]      keysRep;   // levels already reported
      logic [5:0]      keysLast;
      logic [5:0]      pressHist;
      logic [5:0]      relHist;
      logic [7:0]      pressMask;
      logic [7:0]      releaseMask;
      logic            evtValid;
      logic            evtRelease;
      logic [2:0]      evtKey;
      logic [3:0]      failMask;
      logic [3:0]      forced;
      logic [7:0]      failTicks;
      logic [7:0]      failCnt;
      logic [1:0]      failSub;
      logic [3:0][7:0] level;
      logic [3:0][7:0] glitch;
      logic [3:0][7:0] tachBlank;
      logic [7:0]      funcMask;
      logic [7:0]      pulseLen;
      kfp_sw_t         sw;
      logic [8:0]      swCnt;
      logic [21:0]     tickCnt;
      logic [15:0]     stepCnt;
      logic [6:0]      phase;
      logic [3:0]      fanOn;
      logic [3:0]      tachEdge;
      logic            rstOut;
      logic            rstOe;
      logic            pwrOut;
      logic            pwrOe;
      logic            blank;
      logic            restart;
      logic            ignored;
      logic [1:0]      msg;
      logic [7:0]      respType;
      logic [2:0]      respLen;
      logic [4:0][7:0] resp;
      logic [31:0]     cmdData;
      logic [31:0]     rdData;
      logic            ack;
   } kfp_state_t;
endpackage : kfp_pkg
`default_nettype wire

// ---- sim/kfp_fan_model.sv ----
`default_nettype none
module kfp_fan_model (
   // fan drive in, tach out
   input  wire logic       clk,
   input  wire logic [3:0] power,
   output var  logic [3:0] tach
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] div = 3'h0;  // toggle divider
   // tach floats to its pull-up until driven
   initial tach = 4'hF;
   // a powered fan toggles its tach every eighth clock, slow enough for the
   // three-stage input filter; an unpowered one rests at the pull-up level
   always @(posedge clk)
   begin
      div <= div + 3'h1;
      for (int i = 0; i < 4; i++)
         tach[i] <= !power[i] ? 1'h1 : (div == 3'h7) ? ~tach[i] : tach[i];
   end
endmodule : kfp_fan_model
`default_nettype wire

// ---- sim/keypad_fan_power_command_handler_test.sv ----
`default_nettype none
module keypad_fan_power_command_handler_test;
   timeunit 1ns;
   timeprecision 1ns;
   `define CHK(n,e,g) begin checked++; if ((g)!==(e)) begin n_mismatch++; $display("[FAIL] %s exp %h got %h",n,e,g); end end
   logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, hostOn = 0, ack, ev, evRel, rO, rOe, pO, pOe, bl, rs;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0, dOut, rd;
   logic [5:0]  keys = 6'h00;
   logic [3:0]  tach, fanPwr, tEdge, lastEv;
   logic [2:0]  evKey;
   logic [1:0]  msg;
   int          n_mismatch = 0, checked = 0, evCnt = 0, cycN = 0, teCnt = 0, rsCnt = 0;
   always #5 clk = ~clk;
   kfp_handler #(.TICK_CYC(20), .STEP_CYC(4)) u_kfp_handler (.clk(clk), .rst_b(rst_b), .ce(1'h1),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
      .wb_dat_o(dOut), .wb_ack_o(ack), .keysIn(keys), .keyEvtValid(ev), .keyEvtKey(evKey),
      .keyEvtRelease(evRel), .fanTachIn(tach), .fanPowerOut(fanPwr), .tachEdge(tEdge), .hostOnIn(hostOn),
      .hostResetOut(rO), .hostResetOe(rOe), .hostPowerOut(pO), .hostPowerOe(pOe), .displayBlank(bl),
      .msgShow(msg), .selfRestart(rs));
   kfp_fan_model u_kfp_fan_model (.clk(clk), .power(fanPwr), .tach(tach));
   // count key events (keeping the last), fan 0 tach edges and restarts
   always @(posedge clk)
   begin
      if (ev === 1'h1)
      begin
         evCnt++;
         lastEv = {evRel, evKey};
      end
      if (tEdge[0] === 1'h1)
         teCnt++;
      if (rs === 1'h1)
         rsCnt++;
   end
   // hang guard, far above the roughly 4100 cycles the run needs
   always @(posedge clk)
   begin
      cycN++;
      if (cycN == 20000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   // one classic cycle; ack and read data are taken at the edge that shows ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk); while (ack !== 1'h1);
      rd = dOut;
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
   endtask : wb
   // data first, then the command word, then read back the answer header
   task automatic cmd(input logic [7:0] t, input logic [2:0] n, input logic [31:0] d, input logic [31:0] e);
      wb(1'h1, 8'h04, d);
      wb(1'h1, 8'h00, {21'h0, n, t});
      wb(1'h0, 8'h00, 32'h0);
      `CHK("answer", e, rd)
   endtask : cmd
   task automatic nclk(input int n);
      repeat (n) @(posedge clk);
   endtask : nclk
   initial
   begin
      nclk(6);
      rst_b <= 1'h1;
      nclk(4);
      // unconfigured: press and release of the up key both reported
      keys <= 6'h01;
      nclk(10);
      keys <= 6'h00;
      nclk(10);
      `CHK("evCnt", 2, evCnt)
      `CHK("lastEv", 4'h8, lastEv)
      cmd(8'h17, 3'h2, 32'h0, 32'h57);
      evCnt = 0;
      keys <= 6'h01;
      nclk(10);
      keys <= 6'h00;
      nclk(10);
      keys <= 6'h22;
      nclk(10);
      cmd(8'h18, 3'h0, 32'h0, 32'h358);
      wb(1'h0, 8'h08, 32'h0);
      `CHK("poll1", 32'h00012322, rd)
      `CHK("masked", 0, evCnt)
      cmd(8'h18, 3'h0, 32'h0, 32'h358);
      wb(1'h0, 8'h08, 32'h0);
      `CHK("poll2", 32'h00000022, rd)
      keys <= 6'h00;
      cmd(8'h1A, 3'h4, 32'h01020304, 32'h5A);
      `CHK("tachOff", 0, teCnt)
      cmd(8'h11, 3'h4, 32'h30201050, 32'h51);
      cmd(8'h19, 3'h2, 32'h0101, 32'h59);
      nclk(160);
      `CHK("fan0", 1'h1, fanPwr[0])
      `CHK("tach0", 1'h1, teCnt > 0)
      cmd(8'h1B, 3'h0, 32'h0, 32'h55B);
      wb(1'h0, 8'h08, 32'h0);
      `CHK("levels", 32'h30201064, rd)
      wb(1'h0, 8'h0C, 32'h0);
      `CHK("failMask", 32'h01, rd)
      cmd(8'h30, 3'h0, 32'h0, 32'hB0);
      wb(1'h0, 8'h20, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      // keypad reset with inverted polarity: confirm held past 128 ticks
      hostOn <= 1'h1;
      cmd(8'h1C, 3'h1, 32'h22, 32'h5C);
      `CHK("rstIdle", 1'h0, rOe)
      keys <= 6'h02;
      nclk(2700);
      `CHK("rstOe", 1'h1, rOe)
      `CHK("rstOut", 1'h1, rO)
      `CHK("msg", 2'h1, msg)
      keys <= 6'h00;
      nclk(700);
      `CHK("rstRel", 1'h0, rOe)
      `CHK("pwrIdle", 1'h0, pOe)
      // keypad power-on with host off: blanking, inverted 8-tick power pulse
      hostOn <= 1'h0;
      cmd(8'h1C, 3'h2, 32'h0854, 32'h5C);
      `CHK("blank", 1'h1, bl)
      keys <= 6'h02;
      nclk(230);
      `CHK("pwrOe", 1'h1, pOe)
      `CHK("pwrOut", 1'h1, pO)
      `CHK("msgOn", 2'h2, msg)
      keys <= 6'h00;
      nclk(120);
      `CHK("pwrRel", 1'h0, pOe)
      `CHK("restarts", 2, rsCnt)
      print_verdict();
   end
endmodule : keypad_fan_power_command_handler_test
`default_nettype wire
